/* logic/msd_pkg.sv */
// package for the memory space decoder: address map constants and space codes
// assumes a single core clock domain and a core that issues one access per cycle
// Behaviour
// (R01) 16-bit pc, only low 32k backed
// (R02) fetch starts at 0000h after reset
// (R03) fixed vectors, ext interrupt 11 at 000bh
// (R04) vectors 8 bytes apart, unused is code
// (R05) above 7fh direct hits sfr, indirect upper
// (R06) upper ram and sfr share 80h-ffh
// (R07) low 32 bytes: 4 banks of 8
// (R08) two psw bits select active bank
// (R09) 16 bytes above banks bit-addressable
// (R10) low 128 both modes, upper indirect only
// (R11) 256 bytes internal ram, also stack
// (R12) 768 bytes external ram, 27 display
// (R13) 16-bit external address from pointer pair
package msd_pkg;
  localparam int unsigned CODE_SIZE = 32768;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam logic [15:0] EXT11_VECTOR = 16'h000b;
  localparam logic [15:0] VECTOR_STEP = 16'h0008;
  localparam logic [7:0] LOWER_TOP = 8'h7f;
  localparam logic [7:0] BANK_TOP = 8'h1f;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_TOP = 8'h2f;
  localparam int unsigned PSW_BANK_LSB = 3;
  localparam int unsigned EXT_RAM_SIZE = 768;
  localparam int unsigned DISPLAY_SIZE = 27;
  localparam logic [15:0] DISPLAY_BASE = 16'h0000;
  typedef enum logic [2:0] {
    MSD_NONE,
    MSD_LOWER_RAM,
    MSD_UPPER_RAM,
    MSD_SFR,
    MSD_BIT_AREA
  } msd_space_e;
endpackage

/* logic/msd_decoder.sv */
// memory space decoder: steers program, internal and external data addresses
// assumes the core drives request inputs synchronous to core_clk; outputs registered
`timescale 1ns/1ps
module msd_decoder #(
  parameter int unsigned VEC_COUNT = 32,
  parameter int unsigned EXT_RAM_BYTES = msd_pkg::EXT_RAM_SIZE
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] pc_addr,
  input wire logic fetch_req,
  input wire logic irq_take,
  input wire logic [4:0] irq_index,
  input wire logic [7:0] data_addr,
  input wire logic data_req,
  input wire logic data_indirect,
  input wire logic data_is_bank_reg,
  input wire logic data_is_bit,
  input wire logic [7:0] psw,
  input wire logic [7:0] data_pointer_lo,
  input wire logic [7:0] data_pointer_hi,
  input wire logic xdata_req,
  output logic [15:0] fetch_addr,
  output logic code_hit,
  output logic code_miss,
  output logic [7:0] internal_data_ram_addr,
  output logic internal_data_ram_sel,
  output logic sfr_sel,
  output logic [7:0] sfr_addr,
  output logic [2:0] bit_pos,
  output logic [2:0] space,
  output logic [15:0] external_data_ram_addr,
  output logic external_data_ram_sel,
  output logic display_sel,
  output logic xdata_miss
);
  logic first_fetch;
  logic [1:0] bank_sel;
  logic [15:0] data_pointer_pair;

  function automatic logic [15:0] vec_addr(input logic [4:0] idx);
    vec_addr = msd_pkg::VECTOR_BASE + {8'h00, idx, 3'h0}; // [R03] [R04]
  endfunction

  function automatic logic [7:0] bank_addr(input logic [1:0] bk, input logic [2:0] r);
    bank_addr = {3'h0, bk, r}; // [R07]
  endfunction

  // limits are compared at 32 bits so a full 16-bit address cannot wrap
  function automatic logic in_range(input logic [15:0] a, input int unsigned lim);
    in_range = 32'(a) < lim;
  endfunction

  assign bank_sel = psw[msd_pkg::PSW_BANK_LSB +: 2]; // [R08]
  assign data_pointer_pair = {data_pointer_hi, data_pointer_lo}; // [R13]

  // first fetch after reset is forced to the reset vector regardless of pc
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_fetch <= 1'b1;
    end else if (fetch_req) begin
      first_fetch <= 1'b0;
    end
  end

  // vectors sit inside ordinary code, so an unused one simply fetches as code
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fetch_addr <= msd_pkg::RESET_VECTOR;
      code_hit <= 1'b0;
      code_miss <= 1'b0;
    end else begin
      code_hit <= 1'b0;
      code_miss <= 1'b0;
      if (fetch_req) begin
        if (first_fetch) begin
          fetch_addr <= msd_pkg::RESET_VECTOR; // [R02]
          code_hit <= 1'b1;
        end else if (irq_take && 32'(irq_index) < VEC_COUNT) begin
          fetch_addr <= vec_addr(irq_index); // [R03]
          code_hit <= 1'b1;
        end else begin
          fetch_addr <= pc_addr; // [R04]
          code_hit <= in_range(pc_addr, msd_pkg::CODE_SIZE); // [R01]
          code_miss <= !in_range(pc_addr, msd_pkg::CODE_SIZE); // [R01]
        end
      end
    end
  end

  // internal data steering; upper ram and sfr share addresses but not storage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      internal_data_ram_addr <= 8'h00;
      internal_data_ram_sel <= 1'b0;
      sfr_sel <= 1'b0;
      sfr_addr <= 8'h00;
      bit_pos <= 3'h0;
      space <= 3'(msd_pkg::MSD_NONE);
    end else begin
      internal_data_ram_sel <= 1'b0;
      sfr_sel <= 1'b0;
      space <= 3'(msd_pkg::MSD_NONE);
      if (data_req) begin
        if (data_is_bank_reg) begin
          internal_data_ram_addr <= bank_addr(bank_sel, data_addr[2:0]); // [R07] [R08]
          internal_data_ram_sel <= 1'b1;
          space <= 3'(msd_pkg::MSD_LOWER_RAM);
        end else if (data_is_bit && data_addr <= msd_pkg::LOWER_TOP) begin
          internal_data_ram_addr <= msd_pkg::BIT_AREA_BASE + {4'h0, data_addr[6:3]}; // [R09]
          bit_pos <= data_addr[2:0];
          internal_data_ram_sel <= 1'b1;
          space <= 3'(msd_pkg::MSD_BIT_AREA);
        end else if (data_is_bit) begin
          sfr_addr <= {data_addr[7:3], 3'h0};
          bit_pos <= data_addr[2:0];
          sfr_sel <= 1'b1;
          space <= 3'(msd_pkg::MSD_SFR);
        end else if (data_addr <= msd_pkg::LOWER_TOP) begin
          internal_data_ram_addr <= data_addr; // [R10] [R11]
          internal_data_ram_sel <= 1'b1;
          space <= 3'(msd_pkg::MSD_LOWER_RAM);
        end else if (data_indirect) begin
          internal_data_ram_addr <= data_addr; // [R05] [R06] [R10]
          internal_data_ram_sel <= 1'b1;
          space <= 3'(msd_pkg::MSD_UPPER_RAM);
        end else begin
          sfr_addr <= data_addr; // [R05] [R06]
          sfr_sel <= 1'b1;
          space <= 3'(msd_pkg::MSD_SFR);
        end
      end
    end
  end

  // external ram is separate from internal ram and code; out of range is flagged
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      external_data_ram_addr <= 16'h0000;
      external_data_ram_sel <= 1'b0;
      display_sel <= 1'b0;
      xdata_miss <= 1'b0;
    end else begin
      external_data_ram_sel <= 1'b0;
      display_sel <= 1'b0;
      xdata_miss <= 1'b0;
      if (xdata_req) begin
        external_data_ram_addr <= data_pointer_pair; // [R13]
        if (in_range(data_pointer_pair, EXT_RAM_BYTES)) begin
          external_data_ram_sel <= 1'b1; // [R12]
          display_sel <= in_range(data_pointer_pair, msd_pkg::DISPLAY_SIZE); // [R12]
        end else begin
          xdata_miss <= 1'b1;
        end
      end
    end
  end

  // request shapes shared by the checks below; every answer lands one edge later
  sequence s_plain_fetch;
    !first_fetch && fetch_req && !(irq_take && 32'(irq_index) < VEC_COUNT);
  endsequence

  sequence s_vector_fetch;
    !first_fetch && fetch_req && irq_take && 32'(irq_index) < VEC_COUNT;
  endsequence

  sequence s_plain_data;
    data_req && !data_is_bank_reg && !data_is_bit;
  endsequence

  sequence s_bit_data;
    data_req && !data_is_bank_reg && data_is_bit;
  endsequence

  sequence s_bank_data;
    data_req && data_is_bank_reg;
  endsequence

  chk_first_fetch_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // [R02]
    first_fetch && fetch_req |=>
      fetch_addr == msd_pkg::RESET_VECTOR && code_hit)
    else $error("first fetch not at reset vector");

  chk_code_limit: assert property (@(posedge core_clk) disable iff (sys_rst) // [R01]
    code_hit |-> 32'(fetch_addr) < msd_pkg::CODE_SIZE)
    else $error("code hit beyond implemented memory");

  chk_code_miss: assert property (@(posedge core_clk) disable iff (sys_rst) // [R01]
    s_plain_fetch ##0 (32'(pc_addr) >= msd_pkg::CODE_SIZE) |=> code_miss && !code_hit)
    else $error("fetch above implemented memory not flagged");

  chk_hit_miss_excl: assert property (@(posedge core_clk) disable iff (sys_rst) // [R01]
    !(code_hit && code_miss))
    else $error("fetch both hit and missed");

  chk_fetch_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // [R01]
    !fetch_req |=> !code_hit && !code_miss)
    else $error("fetch flags without a fetch");

  chk_ext11_vector: assert property (@(posedge core_clk) disable iff (sys_rst) // [R03]
    s_vector_fetch ##0 (irq_index == 5'd1) |=>
      fetch_addr == msd_pkg::EXT11_VECTOR && code_hit)
    else $error("ext interrupt 11 vector wrong");

  chk_vector_spacing: assert property (@(posedge core_clk) disable iff (sys_rst) // [R04]
    s_vector_fetch |=> fetch_addr ==
      msd_pkg::VECTOR_BASE + 16'($past(irq_index)) * msd_pkg::VECTOR_STEP)
    else $error("vector spacing wrong");

  chk_unused_vector: assert property (@(posedge core_clk) disable iff (sys_rst) // [R04]
    s_plain_fetch |=> fetch_addr == $past(pc_addr))
    else $error("plain fetch not taken from pc");

  chk_direct_sfr: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
    s_plain_data ##0 (!data_indirect && data_addr[7]) |=>
      sfr_sel && !internal_data_ram_sel && sfr_addr == $past(data_addr) &&
      space == 3'(msd_pkg::MSD_SFR))
    else $error("direct upper access not steered to sfr");

  chk_sfr_bit: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
    s_bit_data ##0 data_addr[7] |=>
      sfr_sel && sfr_addr == {$past(data_addr[7:3]), 3'h0} &&
      bit_pos == $past(data_addr[2:0]))
    else $error("upper bit address not steered to sfr");

  chk_data_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
    !data_req |=> !internal_data_ram_sel && !sfr_sel && space == 3'(msd_pkg::MSD_NONE))
    else $error("internal select without a request");

  chk_indirect_upper: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
    s_plain_data ##0 (data_indirect && data_addr[7]) |=>
      internal_data_ram_sel && !sfr_sel && space == 3'(msd_pkg::MSD_UPPER_RAM) &&
      internal_data_ram_addr == $past(data_addr))
    else $error("indirect upper access not steered to ram");

  chk_shared_distinct: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
    !(sfr_sel && internal_data_ram_sel))
    else $error("sfr and ram selected together");

  chk_bank_addr: assert property (@(posedge core_clk) disable iff (sys_rst) // [R07]
    s_bank_data |=> internal_data_ram_addr ==
      {3'h0, $past(psw[4:3]), $past(data_addr[2:0])})
    else $error("bank register address wrong");

  chk_bank_region: assert property (@(posedge core_clk) disable iff (sys_rst) // [R07]
    s_bank_data |=> internal_data_ram_sel && internal_data_ram_addr <= msd_pkg::BANK_TOP &&
      space == 3'(msd_pkg::MSD_LOWER_RAM))
    else $error("bank register outside bank area");

  chk_bank_select: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
    s_bank_data |=> internal_data_ram_addr[4:3] == $past(psw[msd_pkg::PSW_BANK_LSB +: 2]))
    else $error("bank not taken from status word");

  chk_bit_area: assert property (@(posedge core_clk) disable iff (sys_rst) // [R09]
    s_bit_data ##0 !data_addr[7] |=> internal_data_ram_addr >= msd_pkg::BIT_AREA_BASE &&
      internal_data_ram_addr <= msd_pkg::BIT_AREA_TOP)
    else $error("bit address outside bit area");

  chk_bit_byte: assert property (@(posedge core_clk) disable iff (sys_rst) // [R09]
    s_bit_data ##0 !data_addr[7] |=>
      internal_data_ram_addr[3:0] == $past(data_addr[6:3]) &&
      bit_pos == $past(data_addr[2:0]) && space == 3'(msd_pkg::MSD_BIT_AREA))
    else $error("bit address split wrong");

  chk_lower_both: assert property (@(posedge core_clk) disable iff (sys_rst) // [R10]
    s_plain_data ##0 !data_addr[7] |=>
      internal_data_ram_sel && internal_data_ram_addr == $past(data_addr))
    else $error("lower ram not reachable");

  chk_upper_indirect: assert property (@(posedge core_clk) disable iff (sys_rst) // [R10]
    space == 3'(msd_pkg::MSD_UPPER_RAM) |-> $past(data_indirect))
    else $error("upper ram reached without indirect mode");

  chk_stack_reach: assert property (@(posedge core_clk) disable iff (sys_rst) // [R11]
    s_plain_data ##0 data_indirect |=>
      internal_data_ram_sel && internal_data_ram_addr == $past(data_addr))
    else $error("indirect ram byte not reachable");

  chk_external_data_ram_range: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    external_data_ram_sel |-> 32'(external_data_ram_addr) < EXT_RAM_BYTES)
    else $error("external ram select out of range");

  chk_display_part: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    display_sel |-> external_data_ram_sel &&
      32'(external_data_ram_addr) < msd_pkg::DISPLAY_SIZE)
    else $error("display select outside display ram");

  chk_external_data_ram_miss: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    xdata_req && 32'(data_pointer_pair) >= EXT_RAM_BYTES |=>
      xdata_miss && !external_data_ram_sel && !display_sel)
    else $error("external access beyond ram not flagged");

  chk_xdata_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    !xdata_req |=> !external_data_ram_sel && !display_sel && !xdata_miss)
    else $error("external select without a request");

  chk_display_hit: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    xdata_req && 32'(data_pointer_pair) < msd_pkg::DISPLAY_SIZE |=> display_sel)
    else $error("display ram access not flagged");

  chk_external_data_ram_pointer: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
    xdata_req |=> external_data_ram_addr ==
      {$past(data_pointer_hi), $past(data_pointer_lo)})
    else $error("external address not from pointer pair");
endmodule

/* verif/msd_core_model.sv */
// cpu core model: issues one fetch, internal or external access per call
// assumes the caller owns reset and samples the answer right after the call
`timescale 1ns/1ps
module msd_core_model (
  input wire logic core_clk,
  output logic [15:0] pc_addr,
  output logic fetch_req,
  output logic irq_take,
  output logic [4:0] irq_index,
  output logic [7:0] data_addr,
  output logic data_req,
  output logic data_indirect,
  output logic data_is_bank_reg,
  output logic data_is_bit,
  output logic [7:0] psw,
  output logic [7:0] data_pointer_lo,
  output logic [7:0] data_pointer_hi,
  output logic xdata_req
);
  initial begin
    {pc_addr, fetch_req, irq_take, irq_index, data_addr, data_req} = '0;
    {data_indirect, data_is_bank_reg, data_is_bit, psw, xdata_req} = '0;
    {data_pointer_hi, data_pointer_lo} = 16'h0000;
  end
  task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic [4:0] ix,
                       input logic [3:0] c, input logic [7:0] p);
    @(posedge core_clk);
    #1;
    pc_addr = a;
    data_addr = a[7:0];
    {data_pointer_hi, data_pointer_lo} = a;
    {irq_take, data_indirect, data_is_bank_reg, data_is_bit} = c;
    irq_index = ix;
    psw = p;
    fetch_req = (k == 2'd0);
    data_req = (k == 2'd1);
    xdata_req = (k == 2'd2);
    @(posedge core_clk);
    #1;
    {fetch_req, data_req, xdata_req} = 3'h0;
    // stale operands flip so a late sample cannot pass by luck
    pc_addr = ~pc_addr;
    data_addr = ~data_addr;
    {data_pointer_hi, data_pointer_lo} = ~a;
  endtask
endmodule

/* verif/msd_decoder_tb.sv */
// self-checking bench for the memory space decoder, table driven
// assumes the decoder answers each request with a one-cycle strobe
`timescale 1ns/1ps
module msd_decoder_tb;
  typedef struct {logic [1:0] k; logic [15:0] a; logic [4:0] ix; logic [3:0] c;
                  logic [7:0] p; logic [23:0] e;} msd_row_s;
  logic core_clk, sys_rst, fetch_req, irq_take, data_req, data_indirect, data_is_bank_reg;
  logic data_is_bit, xdata_req, code_hit, code_miss, internal_data_ram_sel, sfr_sel;
  logic external_data_ram_sel, display_sel, xdata_miss;
  logic [15:0] pc_addr, fetch_addr, external_data_ram_addr;
  logic [7:0] data_addr, psw, data_pointer_lo, data_pointer_hi, internal_data_ram_addr;
  logic [7:0] sfr_addr;
  logic [4:0] irq_index;
  logic [2:0] bit_pos, space;
  int error_cnt = 0;
  int check_count = 0;
  // bit rows stay last among data rows: bit_pos holds its last value
  msd_row_s rows [22] = '{
    '{0, 16'h1234, 0, 0, 0, 24'h000080}, '{0, 16'h1234, 0, 0, 0, 24'h123480},
    '{0, 16'h7fff, 0, 0, 0, 24'h7fff80}, '{0, 16'h8000, 0, 0, 0, 24'h800040},
    '{0, 16'h1234, 1, 8, 0, 24'h000b80}, '{0, 16'h1234, 7, 8, 0, 24'h003b80},
    '{0, 16'h1234, 8, 8, 0, 24'h123480}, '{0, 16'h000b, 0, 0, 0, 24'h000b80},
    '{1, 16'h0090, 0, 0, 0, 24'h009058}, '{1, 16'h0090, 0, 4, 0, 24'h009090},
    '{1, 16'h007f, 0, 0, 0, 24'h007f88}, '{1, 16'h007f, 0, 4, 0, 24'h007f88},
    '{1, 16'h00ff, 0, 4, 0, 24'h00ff90}, '{1, 16'h0005, 0, 2, 8'h18, 24'h001d88},
    '{1, 16'h0000, 0, 2, 8'h08, 24'h000888}, '{1, 16'h007f, 0, 1, 0, 24'h002fa7},
    '{1, 16'h0000, 0, 1, 0, 24'h0020a0}, '{1, 16'h00d3, 0, 1, 0, 24'h00d05b},
    '{2, 16'h001a, 0, 0, 0, 24'h001ac0},
    '{2, 16'h001b, 0, 0, 0, 24'h001b80}, '{2, 16'h02ff, 0, 0, 0, 24'h02ff80},
    '{2, 16'h0300, 0, 0, 0, 24'h030020}};
  msd_core_model core (.core_clk(core_clk), .pc_addr(pc_addr), .fetch_req(fetch_req),
    .irq_take(irq_take), .irq_index(irq_index), .data_addr(data_addr), .data_req(data_req),
    .data_indirect(data_indirect), .data_is_bank_reg(data_is_bank_reg),
    .data_is_bit(data_is_bit), .psw(psw), .data_pointer_lo(data_pointer_lo),
    .data_pointer_hi(data_pointer_hi), .xdata_req(xdata_req));
  msd_decoder #(.VEC_COUNT(8)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .pc_addr(pc_addr), .fetch_req(fetch_req), .irq_take(irq_take), .irq_index(irq_index),
    .data_addr(data_addr), .data_req(data_req), .data_indirect(data_indirect),
    .data_is_bank_reg(data_is_bank_reg), .data_is_bit(data_is_bit), .psw(psw),
    .data_pointer_lo(data_pointer_lo), .data_pointer_hi(data_pointer_hi),
    .xdata_req(xdata_req), .fetch_addr(fetch_addr), .code_hit(code_hit),
    .code_miss(code_miss), .internal_data_ram_addr(internal_data_ram_addr),
    .internal_data_ram_sel(internal_data_ram_sel), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
    .bit_pos(bit_pos), .space(space), .external_data_ram_addr(external_data_ram_addr),
    .external_data_ram_sel(external_data_ram_sel), .display_sel(display_sel),
    .xdata_miss(xdata_miss));
  function automatic logic [23:0] obs(input logic [1:0] k);
    case (k)
      2'd0: obs = {fetch_addr, code_hit, code_miss, 6'h00};
      2'd1: obs = {8'h00, sfr_sel ? sfr_addr : internal_data_ram_addr,
                   internal_data_ram_sel, sfr_sel, space, bit_pos};
      default: obs = {external_data_ram_addr, external_data_ram_sel, display_sel, xdata_miss,
                      5'h00};
    endcase
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      core.issue(rows[i].k, rows[i].a, rows[i].ix, rows[i].c, rows[i].p);
      check(obs(rows[i].k), rows[i].e);
    end
    // second reset in mid-run: everything clears, first fetch goes to the reset vector
    @(posedge core_clk);
    #1;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    check({fetch_addr, internal_data_ram_addr}, 24'h000000);
    check({external_data_ram_addr, 5'h00, space}, 24'h000000);
    check({17'h00000, code_hit, code_miss, internal_data_ram_sel, sfr_sel,
           external_data_ram_sel, display_sel, xdata_miss}, 24'h000000);
    core.issue(2'd0, 16'h4321, 5'h00, 4'h0, 8'h00);
    check(obs(2'd0), 24'h000080);
    finish_test();
  end
endmodule
